// File: cpes_pkg.sv
// Shared constants and carrier types for the core event selection block.
`default_nettype none
package cpes_pkg;
    // Event numbers and unit masks.
    localparam logic [7:0] EV_STACK = 8'hd1;
    localparam logic [7:0] UM_FOLD = 8'h04;
    localparam logic [7:0] UM_SYNC = 8'h08;
    localparam logic [7:0] EV_ALIAS = 8'hd2;
    localparam logic [7:0] UM_FLAG = 8'h01;
    localparam logic [7:0] UM_PREG = 8'h02;
    localparam logic [7:0] UM_ROB = 8'h04;
    localparam logic [7:0] UM_SER = 8'h08;
    localparam logic [7:0] UM_ANY = 8'h0f;
    localparam logic [7:0] EV_SEG_STALL = 8'hd4;
    localparam logic [7:0] EV_EXTRA_RENAME = 8'hd5;
    localparam logic [7:0] EV_UNFUSE = 8'hdb;
    localparam logic [7:0] EV_BR_DECODE = 8'he0;
    localparam logic [7:0] EV_CALL_RET = 8'he5;
    localparam logic [7:0] UM_ONE = 8'h01;
    // Widths and reset values.
    localparam int CNT_W = 48;
    localparam int SP_W = 32;
    localparam int DELTA_W = 16;
    localparam int STEP_W = 8;
    localparam int FLAG_W = 6;
    localparam int SEG_N = 4;
    localparam logic [FLAG_W-1:0] FLAGS_ALL = 6'h3f;
    localparam logic [FLAG_W-1:0] FLAGS_NONE = 6'h00;
    localparam logic [CNT_W-1:0] CNT_RESET = 48'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 48'h1;
    localparam logic [SP_W-1:0] SP_RESET = 32'h0;
    localparam logic [DELTA_W-1:0] DELTA_RESET = 16'h0;
    // Segment indices.
    localparam logic [1:0] SEG_EXTRA = 2'h0;
    localparam logic [1:0] SEG_DATA = 2'h1;
    localparam logic [1:0] SEG_F = 2'h2;
    localparam logic [1:0] SEG_G = 2'h3;

    typedef enum logic [2:0] {
        SEG_IDLE = 3'h1,
        SEG_RENAMED = 3'h2,
        SEG_BLOCKED = 3'h4
    } cpes_seg_state_e;

    // Per-cycle indications from the core pipeline.
    typedef struct packed {
        logic stack_op;
        logic [STEP_W-1:0] stack_step;
        logic stack_sync;
        logic other_flag_stall;
        logic partial_reg_stall;
        logic reorder_port_stall;
        logic serialize_stall;
        logic fp_status_stall;
        logic unfuse_fp;
        logic branch_decode;
        logic call_ret_miss;
    } cpes_events_s;

    // Flag usage of the instruction being renamed.
    typedef struct packed {
        logic wr_valid;
        logic [FLAG_W-1:0] wr_mask;
        logic rd_valid;
        logic [FLAG_W-1:0] rd_mask;
    } cpes_flags_s;

    // Segment register rename traffic.
    typedef struct packed {
        logic upd_valid;
        logic [1:0] upd_index;
        logic ret_valid;
        logic [1:0] ret_index;
    } cpes_seg_s;
endpackage : cpes_pkg
`default_nettype wire

// File: cpes_seg_track.sv
// One segment register's rename tracker.
`default_nettype none
module cpes_seg_track
    import cpes_pkg::*;
(
    input wire logic core_clk_in, // Core clock.
    input wire logic sys_rst_in, // Asynchronous reset, active high.
    input wire logic update_in, // Write to this segment.
    input wire logic retire_in, // Renamed value retires.
    output logic renamed_out, // Rename done this cycle.
    output logic stall_out // Front end held.
);
    cpes_seg_state_e state_reg;
    cpes_seg_state_e state_next;

    always_comb begin
        state_next = state_reg;
        renamed_out = 1'b0;
        unique case (state_reg)
            SEG_IDLE: begin
                if (update_in) begin
                    state_next = SEG_RENAMED;
                    renamed_out = 1'b1;
                end
            end
            SEG_RENAMED: begin
                if (update_in && !retire_in) begin
                    state_next = SEG_BLOCKED;
                end else if (retire_in && !update_in) begin
                    state_next = SEG_IDLE;
                end else if (retire_in && update_in) begin
                    renamed_out = 1'b1;
                end
            end
            SEG_BLOCKED: begin
                // The held update renames once the older value is gone.
                if (retire_in) begin
                    state_next = SEG_RENAMED;
                    renamed_out = 1'b1;
                end
            end
            default: begin
                state_next = SEG_IDLE;
            end
        endcase
    end

    assign stall_out = (state_reg == SEG_BLOCKED);

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_reg <= SEG_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule : cpes_seg_track
`default_nettype wire

// File: cpes_stack_track.sv
// Stack pointer with a pending delta tracker.
`default_nettype none
module cpes_stack_track
    import cpes_pkg::*;
(
    input wire logic core_clk_in, // Core clock.
    input wire logic sys_rst_in, // Asynchronous reset, active high.
    input wire logic op_in, // Stack instruction decoded.
    input wire logic [STEP_W-1:0] step_in, // Signed pointer change.
    input wire logic sync_in, // Fold delta into pointer.
    output logic [SP_W-1:0] stack_pointer_out, // Architectural pointer.
    output logic [DELTA_W-1:0] delta_out // Pending delta.
);
    logic [SP_W-1:0] sp_reg;
    logic [SP_W-1:0] sp_next;
    logic [DELTA_W-1:0] delta_reg;
    logic [DELTA_W-1:0] delta_next;
    logic [DELTA_W-1:0] step_ext;

    always_comb begin
        step_ext = {{(DELTA_W-STEP_W){step_in[STEP_W-1]}}, step_in};
        sp_next = sp_reg;
        delta_next = delta_reg;
        if (sync_in) begin
            // A stack op in the sync cycle starts the fresh delta.
            sp_next = sp_reg + {{(SP_W-DELTA_W){delta_reg[DELTA_W-1]}}, delta_reg};
            delta_next = op_in ? step_ext : DELTA_RESET;
        end else if (op_in) begin
            delta_next = delta_reg + step_ext;
        end
    end

    assign stack_pointer_out = sp_reg;
    assign delta_out = delta_reg;

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sp_reg <= SP_RESET;
            delta_reg <= DELTA_RESET;
        end else begin
            sp_reg <= sp_next;
            delta_reg <= delta_next;
        end
    end
endmodule : cpes_stack_track
`default_nettype wire

// File: cpes_event_select.sv
// Core performance event selection and counting.
// Operation
// - Count decoded stack-pointer instructions on d1/04.
// - Stack ops update delta tracker, no uop.
// - Count sync operations folding delta on d1/08.
// - Count flag stall cycles on d2/01.
// - Partial flag stall: unwritten flags read next.
// - Count partial register latency cycles on d2/02.
// - Count reorder port stall cycles each retry.
// - Count serialization scoreboard stall cycles on d2/08.
// - d2/0f counts any of flag, partial register, reorder port or FP status stalls.
// - Count segment renaming stall cycles on d4/01.
// - Second update to renamed segment stalls front.
// - Count extra data segment renames on d5/01.
// - Count floating-point unfusions on db/01.
// - Count decoded branches on e0/01.
// - Count call or return mispredictions on e5/01.
`default_nettype none
module cpes_event_select
    import cpes_pkg::*;
(
    input wire logic core_clk_in, // Core clock, 40 MHz.
    input wire logic sys_rst_in, // Asynchronous reset, active high.
    input wire logic count_enable_in, // Counting allowed.
    input wire logic count_clear_in, // Zero the counter.
    input wire logic [7:0] event_select_in, // Event number.
    input wire logic [7:0] unit_mask_in, // Unit mask.
    input wire cpes_events_s events_in, // Pipeline indications.
    input wire cpes_flags_s flags_in, // Flag use this cycle.
    input wire cpes_seg_s seg_in, // Segment rename traffic.
    output logic [CNT_W-1:0] count_out, // Event count.
    output logic flag_stall_out, // Partial flag stall seen.
    output logic [SEG_N-1:0] seg_stall_out, // Per-segment front stall.
    output logic [SP_W-1:0] stack_pointer_out, // Stack pointer.
    output logic [DELTA_W-1:0] stack_delta_out // Pending stack delta.
);
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic [FLAG_W-1:0] last_wr_reg;
    logic [FLAG_W-1:0] last_wr_next;
    logic last_valid_reg;
    logic last_valid_next;
    logic flag_stall_reg;
    logic flag_stall_next;
    logic partial_flag_hit;
    logic flag_cycle;
    logic seg_cycle;
    logic extra_renamed;
    logic any_stall;
    logic hit;
    logic [SEG_N-1:0] seg_upd;
    logic [SEG_N-1:0] seg_ret;
    logic [SEG_N-1:0] seg_renamed;
    logic [SEG_N-1:0] seg_blocked;

    // Flag tracking: remember the flags written by the last writer.
    always_comb begin
        last_wr_next = last_wr_reg;
        last_valid_next = last_valid_reg;
        partial_flag_hit = 1'b0;
        if (flags_in.rd_valid && last_valid_reg) begin
            // Only a partial writer can leave stale flags behind.
            partial_flag_hit = (last_wr_reg != FLAGS_ALL) &&
                ((flags_in.rd_mask & ~last_wr_reg) != FLAGS_NONE);
        end
        if (flags_in.wr_valid) begin
            last_wr_next = flags_in.wr_mask;
            last_valid_next = 1'b1;
        end else if (flags_in.rd_valid) begin
            // The reader was the next instruction; the pair is closed.
            last_valid_next = 1'b0;
        end
        flag_stall_next = partial_flag_hit;
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            last_wr_reg <= FLAGS_ALL;
            last_valid_reg <= 1'b0;
            flag_stall_reg <= 1'b0;
        end else begin
            last_wr_reg <= last_wr_next;
            last_valid_reg <= last_valid_next;
            flag_stall_reg <= flag_stall_next;
        end
    end

    assign flag_stall_out = flag_stall_reg;

    // Segment rename trackers, one per data segment register.
    genvar g;
    generate
        for (g = 0; g < SEG_N; g++) begin : g_seg
            assign seg_upd[g] = seg_in.upd_valid && (seg_in.upd_index == 2'(g));
            assign seg_ret[g] = seg_in.ret_valid && (seg_in.ret_index == 2'(g));
            cpes_seg_track u_seg (
                .core_clk_in(core_clk_in),
                .sys_rst_in(sys_rst_in),
                .update_in(seg_upd[g]),
                .retire_in(seg_ret[g]),
                .renamed_out(seg_renamed[g]),
                .stall_out(seg_blocked[g])
            );
        end
    endgenerate

    assign seg_stall_out = seg_blocked;

    // Stack pointer folding.
    cpes_stack_track u_stack (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .op_in(events_in.stack_op),
        .step_in(events_in.stack_step),
        .sync_in(events_in.stack_sync),
        .stack_pointer_out(stack_pointer_out),
        .delta_out(stack_delta_out)
    );

    // Derived stall conditions.
    always_comb begin
        flag_cycle = events_in.other_flag_stall || partial_flag_hit;
        seg_cycle = |seg_blocked;
        extra_renamed = seg_renamed[SEG_EXTRA];
        any_stall = events_in.reorder_port_stall || events_in.partial_reg_stall ||
            flag_cycle || events_in.fp_status_stall;
    end

    // Event selection: exact number and mask must both match.
    always_comb begin
        hit = 1'b0;
        unique case (event_select_in)
            EV_STACK: begin
                if (unit_mask_in == UM_FOLD) begin
                    hit = events_in.stack_op;
                end else if (unit_mask_in == UM_SYNC) begin
                    hit = events_in.stack_sync;
                end
            end
            EV_ALIAS: begin
                unique case (unit_mask_in)
                    UM_FLAG: hit = flag_cycle;
                    UM_PREG: hit = events_in.partial_reg_stall;
                    UM_ROB: hit = events_in.reorder_port_stall;
                    UM_SER: hit = events_in.serialize_stall;
                    UM_ANY: hit = any_stall;
                    default: hit = 1'b0;
                endcase
            end
            EV_SEG_STALL: begin
                hit = (unit_mask_in == UM_ONE) && seg_cycle;
            end
            EV_EXTRA_RENAME: begin
                hit = (unit_mask_in == UM_ONE) && extra_renamed;
            end
            EV_UNFUSE: begin
                hit = (unit_mask_in == UM_ONE) && events_in.unfuse_fp;
            end
            EV_BR_DECODE: begin
                hit = (unit_mask_in == UM_ONE) && events_in.branch_decode;
            end
            EV_CALL_RET: begin
                hit = (unit_mask_in == UM_ONE) && events_in.call_ret_miss;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // Counter: clear wins over an event in the same cycle.
    always_comb begin
        count_next = count_reg;
        if (count_clear_in) begin
            count_next = CNT_RESET;
        end else if (count_enable_in && hit) begin
            count_next = count_reg + CNT_ONE;
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            count_reg <= CNT_RESET;
        end else begin
            count_reg <= count_next;
        end
    end

    assign count_out = count_reg;
endmodule : cpes_event_select
`default_nettype wire

// File: cpes_pipe_model.sv
// Behavioural model of the core pipeline that feeds event indications.
`default_nettype none
module cpes_pipe_model
    import cpes_pkg::*;
(
    output var cpes_events_s events_out, // Event indications.
    output var cpes_flags_s flags_out, // Flag use.
    output var cpes_seg_s seg_out // Segment traffic.
);
    timeunit 1ns;
    timeprecision 1ps;
    // Indications are plain levels, so the bench changes them only at the falling edge.
    initial begin
        events_out = '0;
        flags_out = '0;
        seg_out = '0;
    end
    task automatic put(input cpes_events_s e, input cpes_flags_s f, input cpes_seg_s s);
        events_out = e;
        flags_out = f;
        seg_out = s;
    endtask : put
endmodule : cpes_pipe_model
`default_nettype wire

// File: cpes_event_select_asserts.sv
// Assertion checker for the core event selection block.
`default_nettype none
module cpes_event_select_asserts
    import cpes_pkg::*;
(
    input wire logic core_clk_in, // Clock.
    input wire logic sys_rst_in, // Reset.
    input wire logic count_enable_in, // Enable.
    input wire logic count_clear_in, // Clear.
    input wire logic [7:0] event_select_in, // Event.
    input wire logic [7:0] unit_mask_in, // Mask.
    input wire cpes_events_s events_in, // Events.
    input wire cpes_flags_s flags_in, // Flags.
    input wire cpes_seg_s seg_in, // Segments.
    input wire logic [CNT_W-1:0] count_out, // Count.
    input wire logic flag_stall_out, // Flag stall.
    input wire logic [SEG_N-1:0] seg_stall_out, // Segment stall.
    input wire logic [SP_W-1:0] stack_pointer_out, // Pointer.
    input wire logic [DELTA_W-1:0] stack_delta_out // Delta.
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence pick_s(logic [7:0] ev, logic [7:0] um, logic cond);
        count_enable_in && !count_clear_in && event_select_in == ev && unit_mask_in == um && cond;
    endsequence
    property bump_p(logic [7:0] ev, logic [7:0] um, logic cond);
        pick_s(ev, um, cond) |=> count_out == $past(count_out) + CNT_ONE;
    endproperty
    fold_count_a: assert property (bump_p(EV_STACK, UM_FOLD, events_in.stack_op))
        else $error("fold count missed");
    sync_count_a: assert property (bump_p(EV_STACK, UM_SYNC, events_in.stack_sync))
        else $error("sync count missed");
    reorder_count_a: assert property (bump_p(EV_ALIAS, UM_ROB, events_in.reorder_port_stall))
        else $error("reorder stall count missed");
    any_stall_a: assert property (bump_p(EV_ALIAS, UM_ANY, events_in.fp_status_stall))
        else $error("any stall count missed");
    branch_count_a: assert property (bump_p(EV_BR_DECODE, UM_ONE, events_in.branch_decode))
        else $error("branch count missed");
    call_miss_a: assert property (bump_p(EV_CALL_RET, UM_ONE, events_in.call_ret_miss))
        else $error("call return miss count missed");
    hold_idle_a: assert property (!count_enable_in && !count_clear_in |=> $stable(count_out))
        else $error("count moved while disabled");
    delta_step_a: assert property (events_in.stack_op && !events_in.stack_sync |=>
        stack_delta_out == $past(stack_delta_out) + DELTA_W'(signed'($past(events_in.stack_step)))
        && $stable(stack_pointer_out)) else $error("delta tracker wrong");
    seg_hold_a: assert property (seg_stall_out[0] &&
        !(seg_in.ret_valid && seg_in.ret_index == SEG_EXTRA) |=> seg_stall_out[0])
        else $error("segment stall released early");
endmodule : cpes_event_select_asserts
bind cpes_event_select cpes_event_select_asserts u_chk (.core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in), .count_enable_in(count_enable_in), .count_clear_in(count_clear_in),
    .event_select_in(event_select_in), .unit_mask_in(unit_mask_in), .events_in(events_in),
    .flags_in(flags_in), .seg_in(seg_in), .count_out(count_out), .flag_stall_out(flag_stall_out),
    .seg_stall_out(seg_stall_out), .stack_pointer_out(stack_pointer_out),
    .stack_delta_out(stack_delta_out));
`default_nettype wire

// File: cpes_event_select_test.sv
// Self-checking testbench for the core event selection block.
`default_nettype none
module cpes_event_select_test
    import cpes_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Each entry is event number, unit mask and the bit of the event struct that feeds it.
    localparam logic [23:0] TBL [10] = '{24'hd10411, 24'hd10808, 24'hd20107, 24'hd20206,
        24'hd20405, 24'hd20804, 24'hd20f03, 24'hdb0102, 24'he00101, 24'he50100};
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic en = 1'b1;
    logic clr = 1'b0;
    logic [7:0] sel = 8'h00;
    logic [7:0] msk = 8'h00;
    cpes_events_s ev;
    cpes_flags_s fl;
    cpes_seg_s sg;
    logic [CNT_W-1:0] cnt;
    logic fstall;
    logic [SEG_N-1:0] sstall;
    logic [SP_W-1:0] sp;
    logic [DELTA_W-1:0] dl;
    int err_count = 0;
    int tests_run = 0;
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    cpes_pipe_model pipe (.events_out(ev), .flags_out(fl), .seg_out(sg));
    cpes_event_select dut (.core_clk_in(core_clk), .sys_rst_in(sys_rst), .count_enable_in(en),
        .count_clear_in(clr), .event_select_in(sel), .unit_mask_in(msk), .events_in(ev),
        .flags_in(fl), .seg_in(sg), .count_out(cnt), .flag_stall_out(fstall),
        .seg_stall_out(sstall), .stack_pointer_out(sp), .stack_delta_out(dl));
    task automatic chk(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask : tick
    // Clearing on every new selection keeps one scenario's counts out of the next.
    task automatic pick(input logic [7:0] e, input logic [7:0] m);
        @(negedge core_clk);
        sel = e;
        msk = m;
        clr = 1'b1;
        pipe.put('0, '0, '0);
        @(negedge core_clk);
        clr = 1'b0;
    endtask : pick
    task automatic t_stack();
        pick(8'hd1, 8'h04);
        pipe.put(cpes_events_s'(18'h3f800), '0, '0);
        tick(2);
        pipe.put(cpes_events_s'(18'h00100), '0, '0);
        chk(dl, 48'hfff8);
        chk(sp, 48'h0);
        chk(cnt, 48'h2);
        tick(1);
        pipe.put('0, '0, '0);
        chk(sp, 48'hfffffff8);
        chk(dl, 48'h0);
    endtask : t_stack
    task automatic t_simple();
        for (int i = 0; i < 10; i++) begin
            pick(TBL[i][23:16], TBL[i][15:8]);
            pipe.put(cpes_events_s'(18'h1 << TBL[i][4:0]), '0, '0);
            tick(3);
            pipe.put('0, '0, '0);
            tick(2);
            chk(cnt, 48'h3);
        end
    endtask : t_simple
    task automatic t_reject();
        pick(8'hd1, 8'h04);
        pipe.put(cpes_events_s'(18'h1ffff), '0, '0);
        tick(2);
        en = 1'b0;
        pipe.put(cpes_events_s'(18'h3ffff), '0, '0);
        tick(2);
        en = 1'b1;
        chk(cnt, 48'h0);
        pick(8'hd2, 8'h0f);
        pipe.put(cpes_events_s'(18'h00010), '0, '0);
        tick(2);
        chk(cnt, 48'h0);
        pick(8'hd2, 8'h10);
        pipe.put(cpes_events_s'(18'h3ffff), '0, '0);
        tick(2);
        chk(cnt, 48'h0);
    endtask : t_reject
    task automatic t_flags();
        pick(8'hd2, 8'h01);
        pipe.put('0, cpes_flags_s'{1'b1, 6'h01, 1'b0, 6'h00}, '0);
        tick(1);
        pipe.put('0, cpes_flags_s'{1'b0, 6'h00, 1'b1, 6'h02}, '0);
        tick(1);
        pipe.put('0, cpes_flags_s'{1'b1, 6'h03, 1'b0, 6'h00}, '0);
        chk(fstall, 48'h1);
        chk(cnt, 48'h1);
        tick(1);
        pipe.put('0, cpes_flags_s'{1'b0, 6'h00, 1'b1, 6'h01}, '0);
        chk(fstall, 48'h0);
        tick(2);
        chk(cnt, 48'h1);
    endtask : t_flags
    task automatic t_seg();
        int blocked;
        blocked = 0;
        pick(8'hd4, 8'h01);
        for (int c = 0; c < 10; c++) begin
            if (sstall[0] === 1'b1) begin
                blocked++;
            end
            if (c == 4) begin
                chk(sstall, 48'h1);
            end
            pipe.put('0, '0, cpes_seg_s'{c < 2, 2'h0, c == 5, 2'h0});
            tick(1);
        end
        // The second update blocks from the second edge until the retire edge: four cycles.
        chk(cnt, 48'h4);
        chk(48'(blocked), 48'h4);
        chk(sstall, 48'h0);
        pipe.put('0, '0, cpes_seg_s'{1'b0, 2'h0, 1'b1, 2'h0});
        tick(1);
        pick(8'hd5, 8'h01);
        for (int c = 0; c < 3; c++) begin
            pipe.put('0, '0, cpes_seg_s'{1'b1, 2'(c), 1'b0, 2'h0});
            tick(1);
        end
        pipe.put('0, '0, '0);
        tick(1);
        chk(cnt, 48'h1);
    endtask : t_seg
    task automatic print_verdict();
        if (err_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (3000) @(posedge core_clk);
        err_count++;
        print_verdict();
    end
    initial begin
        repeat (6) @(negedge core_clk);
        sys_rst = 1'b0;
        t_stack();
        t_simple();
        t_reject();
        t_flags();
        t_seg();
        print_verdict();
    end
endmodule : cpes_event_select_test
`default_nettype wire
